/* hw/pifb_bank.sv */
// peripheral interrupt flag, enable and priority bank with APB register access
module pifb_bank
	import pifb_pkg::*;
#(
	parameter bit PIN28 = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pifb_events_s events,
	input wire pifb_ccp_mode_e capcomp_one_mode,
	input wire pifb_ccp_mode_e capcomp_two_mode,
	output pifb_req_s irq_req
);

	logic [7:0] ext_irq_ctrl_three;
	logic [7:0] periph_irq_flags_one;
	logic [7:0] periph_irq_flags_two;
	logic [7:0] periph_irq_enables_one;
	logic [7:0] periph_irq_enables_two;
	logic [2:0] global_ctrl;
	logic [15:0] periph_priority;

	logic setup;
	logic wr;
	logic lane0;
	logic [7:0] wbyte;
	logic [7:0] one_set;
	logic [7:0] two_set;
	logic [7:0] one_writable;
	logic [7:0] one_impl;
	logic [15:0] periph_active;
	logic ext_a_active;
	logic ext_b_active;
	logic next_high;
	logic next_low;

	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		case (a)
			OFF_EXT_CTRL, OFF_FLAGS_ONE, OFF_FLAGS_TWO, OFF_ENABLES_ONE,
			OFF_ENABLES_TWO, OFF_GLOBAL_CTRL, OFF_PERIPH_PRIO, OFF_REQ_STATUS: addr_known = 1'b1;
			default: addr_known = 1'b0;
		endcase
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// zero-wait slave: read data is latched in the setup cycle
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite & addr_known(paddr);
	assign lane0 = pstrb[0];
	assign wbyte = pwdata[7:0];
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_known(paddr);

	assign one_impl = PIN28 ? 8'h007f : 8'h00ff; // [R09]
	// receive and transmit flags follow their buffers and are not writable
	assign one_writable = one_impl & ~(8'h0001 << SERIAL_RX_BIT) & ~(8'h0001 << SERIAL_TX_BIT);

	// hardware set terms, independent of any enable [R05]
	always_comb begin
		one_set = ZERO_BYTE; // [R08]
		one_set[PARALLEL_BIT] = events.parallel_port;
		one_set[6] = events.conversion_done;
		one_set[3] = events.sync_serial_done; // [R17]
		one_set[2] = (events.capcomp_one_capture & (capcomp_one_mode == PIFB_CCP_CAPTURE))
			| (events.capcomp_one_match & (capcomp_one_mode == PIFB_CCP_COMPARE)); // [R12]
		one_set[1] = events.timer_two_match;
		one_set[0] = events.timer_one_overflow;
		two_set = ZERO_BYTE; // [R13]
		two_set[7] = events.osc_fail; // [R14]
		two_set[6] = events.comparator_change; // [R16]
		two_set[3] = events.bus_collision; // [R18]
		two_set[2] = events.low_voltage; // [R15]
		two_set[1] = events.timer_three_overflow;
		two_set[0] = (events.capcomp_two_capture & (capcomp_two_mode == PIFB_CCP_CAPTURE))
			| (events.capcomp_two_match & (capcomp_two_mode == PIFB_CCP_COMPARE)); // [R12]
	end

	// ext_irq_ctrl_three: priorities, enables and sticky flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_irq_ctrl_three <= EXT_CTRL_RESET;
		end else begin
			if (wr && lane0 && hit(paddr, OFF_EXT_CTRL)) begin
				ext_irq_ctrl_three[EXT_B_PRIO_BIT] <= wbyte[EXT_B_PRIO_BIT]; // [R01]
				ext_irq_ctrl_three[EXT_A_PRIO_BIT] <= wbyte[EXT_A_PRIO_BIT]; // [R01]
				ext_irq_ctrl_three[EXT_B_EN_BIT] <= wbyte[EXT_B_EN_BIT]; // [R02]
				ext_irq_ctrl_three[EXT_A_EN_BIT] <= wbyte[EXT_A_EN_BIT]; // [R02]
				ext_irq_ctrl_three[EXT_B_FLAG_BIT] <= wbyte[EXT_B_FLAG_BIT] | events.ext_b; // [R23]
				ext_irq_ctrl_three[EXT_A_FLAG_BIT] <= wbyte[EXT_A_FLAG_BIT] | events.ext_a; // [R23]
			end else begin
				if (events.ext_b) begin
					ext_irq_ctrl_three[EXT_B_FLAG_BIT] <= 1'b1; // [R03] [R05]
				end
				if (events.ext_a) begin
					ext_irq_ctrl_three[EXT_A_FLAG_BIT] <= 1'b1; // [R03] [R05]
				end
			end
			ext_irq_ctrl_three[5] <= 1'b0; // [R04]
			ext_irq_ctrl_three[2] <= 1'b0; // [R04]
		end
	end

	// sticky peripheral flags except the rx and tx buffer levels, set wins over a same-cycle write
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					periph_irq_flags_one[gi] <= 1'b0;
					periph_irq_flags_two[gi] <= 1'b0;
				end else begin
					if (gi == SERIAL_RX_BIT) begin
						periph_irq_flags_one[gi] <= events.rx_buffer_full; // [R10]
					end else if (gi == SERIAL_TX_BIT) begin
						periph_irq_flags_one[gi] <= events.tx_buffer_empty; // [R11]
					end else if (!one_impl[gi]) begin
						periph_irq_flags_one[gi] <= 1'b0; // [R09]
					end else if (one_set[gi]) begin
						periph_irq_flags_one[gi] <= 1'b1; // [R23]
					end else if (wr && lane0 && hit(paddr, OFF_FLAGS_ONE) && one_writable[gi]) begin
						periph_irq_flags_one[gi] <= wbyte[gi];
					end
					if (!TWO_IMPL_MASK[gi]) begin
						periph_irq_flags_two[gi] <= 1'b0; // [R13]
					end else if (two_set[gi]) begin
						periph_irq_flags_two[gi] <= 1'b1; // [R23]
					end else if (wr && lane0 && hit(paddr, OFF_FLAGS_TWO)) begin
						periph_irq_flags_two[gi] <= wbyte[gi];
					end
				end
			end
		end
	endgenerate

	// enables, one per flag position
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_irq_enables_one <= ZERO_BYTE;
			periph_irq_enables_two <= ZERO_BYTE;
		end else begin
			if (wr && lane0 && hit(paddr, OFF_ENABLES_ONE)) begin
				periph_irq_enables_one <= wbyte & one_impl; // [R19] [R09]
			end
			if (wr && lane0 && hit(paddr, OFF_ENABLES_TWO)) begin
				periph_irq_enables_two <= wbyte & TWO_IMPL_MASK; // [R20]
			end
		end
	end

	// global enables, priority feature and peripheral priorities
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_ctrl <= GLOBAL_CTRL_RESET;
			periph_priority <= PERIPH_PRIO_RESET;
		end else begin
			if (wr && lane0 && hit(paddr, OFF_GLOBAL_CTRL)) begin
				global_ctrl <= wbyte[2:0];
			end
			if (wr && hit(paddr, OFF_PERIPH_PRIO)) begin
				if (pstrb[0]) begin
					periph_priority[7:0] <= wbyte & one_impl;
				end
				if (pstrb[1]) begin
					periph_priority[15:8] <= pwdata[15:8] & TWO_IMPL_MASK;
				end
			end
		end
	end

	// request routing
	assign periph_active = {periph_irq_flags_two & periph_irq_enables_two,
		periph_irq_flags_one & periph_irq_enables_one}; // [R24]
	assign ext_a_active = ext_irq_ctrl_three[EXT_A_FLAG_BIT] & ext_irq_ctrl_three[EXT_A_EN_BIT];
	assign ext_b_active = ext_irq_ctrl_three[EXT_B_FLAG_BIT] & ext_irq_ctrl_three[EXT_B_EN_BIT];

	always_comb begin
		if (global_ctrl[PRIO_FEAT_BIT]) begin
			// global bit gates high, both bits gate low [R21]
			next_high = global_ctrl[GLOBAL_EN_BIT]
				& ((|(periph_active & periph_priority))
				| (ext_a_active & ext_irq_ctrl_three[EXT_A_PRIO_BIT])
				| (ext_b_active & ext_irq_ctrl_three[EXT_B_PRIO_BIT])); // [R24] [R01]
			next_low = global_ctrl[GLOBAL_EN_BIT] & global_ctrl[PERIPH_EN_BIT]
				& ((|(periph_active & ~periph_priority))
				| (ext_a_active & ~ext_irq_ctrl_three[EXT_A_PRIO_BIT])
				| (ext_b_active & ~ext_irq_ctrl_three[EXT_B_PRIO_BIT])); // [R24]
		end else begin
			// compatibility: priorities ignored, all on the high request [R22]
			next_high = global_ctrl[GLOBAL_EN_BIT]
				& ((global_ctrl[PERIPH_EN_BIT] & (|periph_active)) // [R07]
				| ext_a_active | ext_b_active); // [R21]
			next_low = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_req <= '0;
		end else begin
			irq_req.high <= next_high; // [R24]
			irq_req.low <= next_low;
		end
	end

	// read data, captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup && !pwrite) begin
			case (paddr)
				OFF_EXT_CTRL: prdata <= {24'h0000_00, ext_irq_ctrl_three};
				OFF_FLAGS_ONE: prdata <= {24'h0000_00, periph_irq_flags_one};
				OFF_FLAGS_TWO: prdata <= {24'h0000_00, periph_irq_flags_two};
				OFF_ENABLES_ONE: prdata <= {24'h0000_00, periph_irq_enables_one};
				OFF_ENABLES_TWO: prdata <= {24'h0000_00, periph_irq_enables_two};
				OFF_GLOBAL_CTRL: prdata <= {29'h0000_0000, global_ctrl};
				OFF_PERIPH_PRIO: prdata <= {16'h0000, periph_priority};
				OFF_REQ_STATUS: prdata <= {30'h0000_0000, irq_req.high, irq_req.low};
				default: prdata <= '0;
			endcase
		end
	end

endmodule // pifb_bank

/* pkg/pifb_pkg.sv */
// constants, types and register map of the peripheral interrupt flag/enable bank
// Operation
// R01: ext_irq_ctrl_three bits 7 and 6 hold ext_b and ext_a priority, 1 high.
// R02: ext_irq_ctrl_three bits 4 and 3 enable ext_b and ext_a interrupts.
// R03: bits 1 and 0 flag ext_b and ext_a events, held until software clears.
// R04: ext_irq_ctrl_three bits 5 and 2 ignore writes and read zero.
// R05: every flag sets on its event regardless of any enable.
// R06: software clears a flag before enabling and after servicing its interrupt.
// R07: without priority feature, peripheral requests also need peripheral_global_enable.
// R08: flags_one holds parallel, conversion, rx, tx, sync, capcomp1, timer2, timer1.
// R09: on 28-pin parts the parallel port flag and enable read zero.
// R10: serial_rx_flag is read-only, high while the receive buffer holds data.
// R11: serial_tx_flag is read-only, high while the transmit buffer is empty.
// R12: capcomp flags set on capture in capture mode, match in compare mode.
// R13: flags_two holds osc fail, comparator, two zero bits, collision, voltage, timer3, capcomp2.
// R14: osc_fail_flag sets on oscillator failure and holds until cleared.
// R15: voltage_detect_flag sets on low voltage and holds after recovery.
// R16: comparator_flag sets on comparator input change and holds until cleared.
// R17: sync_serial_flag sets on transfer completion and software clears it.
// R18: bus_collision_flag sets on collision and holds until cleared.
// R19: enables_one places one enable at each flags_one bit position.
// R20: enables_two mirrors flags_two positions; bits 5 and 4 read zero.
// R21: flag, enable and matching global enable together request the chosen priority.
// R22: with priority feature off, all priority bits ignored; everything goes high.
// R23: event pulses captured on the clock; a set beats a same-cycle clear.
// R24: separate high and low request outputs, AND of flag and enable, routed by priority.
package pifb_pkg;

	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_EXT_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_FLAGS_ONE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_FLAGS_TWO = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_ENABLES_ONE = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_ENABLES_TWO = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_GLOBAL_CTRL = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_PERIPH_PRIO = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_REQ_STATUS = 8'h1c;

	// ext_irq_ctrl_three fields
	localparam int EXT_B_PRIO_BIT = 7;
	localparam int EXT_A_PRIO_BIT = 6;
	localparam int EXT_B_EN_BIT = 4;
	localparam int EXT_A_EN_BIT = 3;
	localparam int EXT_B_FLAG_BIT = 1;
	localparam int EXT_A_FLAG_BIT = 0;
	localparam logic [7:0] EXT_CTRL_RESET = 8'h00c0;

	// flags_one / enables_one positions
	localparam int PARALLEL_BIT = 7;
	localparam int SERIAL_RX_BIT = 5;
	localparam int SERIAL_TX_BIT = 4;
	// implemented bits of the second flag and enable registers
	localparam logic [7:0] TWO_IMPL_MASK = 8'h00cf;
	localparam logic [7:0] ZERO_BYTE = 8'h0000;

	// global control fields
	localparam int GLOBAL_EN_BIT = 0;
	localparam int PERIPH_EN_BIT = 1;
	localparam int PRIO_FEAT_BIT = 2;
	localparam logic [2:0] GLOBAL_CTRL_RESET = 3'h0;
	localparam logic [15:0] PERIPH_PRIO_RESET = 16'hcfff;

	typedef enum logic [1:0] {
		PIFB_CCP_OFF = 2'b00,
		PIFB_CCP_CAPTURE = 2'b01,
		PIFB_CCP_COMPARE = 2'b10,
		PIFB_CCP_PWM = 2'b11
	} pifb_ccp_mode_e;

	// one-cycle event pulses and levels from peripherals, same clock domain
	typedef struct packed {
		logic ext_b;
		logic ext_a;
		logic parallel_port;
		logic conversion_done;
		logic rx_buffer_full;
		logic tx_buffer_empty;
		logic sync_serial_done;
		logic capcomp_one_capture;
		logic capcomp_one_match;
		logic timer_two_match;
		logic timer_one_overflow;
		logic osc_fail;
		logic comparator_change;
		logic bus_collision;
		logic low_voltage;
		logic timer_three_overflow;
		logic capcomp_two_capture;
		logic capcomp_two_match;
	} pifb_events_s;

	typedef struct packed {
		logic high;
		logic low;
	} pifb_req_s;

endpackage : pifb_pkg

/* bench/pifb_src.sv */
// model of the event sources: bench pulses, buffer levels held
module pifb_src
	import pifb_pkg::*;
(
	input wire logic [17:0] fire,
	input wire logic rx_full,
	input wire logic tx_empty,
	output pifb_events_s events
);
	timeunit 1ns;
	timeprecision 1ns;
	always_comb begin
		events = pifb_events_s'(fire);
		events.rx_buffer_full = rx_full;
		events.tx_buffer_empty = tx_empty;
	end
endmodule // pifb_src

/* bench/pifb_bank_sva.sv */
// port assertions of the interrupt flag bank
module pifb_bank_sva
	import pifb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire pifb_events_s events
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rda;
	assign rda = psel && penable && !pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	unmapped_err_a: assert property (psel && penable && paddr > OFF_REQ_STATUS |-> pslverr)
		else $error("no error on unmapped");
	unmapped_zero_a: assert property (rda && paddr > OFF_REQ_STATUS |-> prdata == '0)
		else $error("unmapped read not zero");
	ctrl_gaps_a: assert property (rda && paddr == OFF_EXT_CTRL |-> !prdata[5] && !prdata[2])
		else $error("ctrl gap bits set");
	flag_gaps_a: assert property (rda && paddr == OFF_FLAGS_TWO |-> prdata[5:4] == 2'b00)
		else $error("flag gap bits set");
	enable_gaps_a: assert property (rda && paddr == OFF_ENABLES_TWO |-> prdata[5:4] == 2'b00)
		else $error("enable gap bits set");
	rx_level_a: assert property (rda && paddr == OFF_FLAGS_ONE
		|-> prdata[SERIAL_RX_BIT] == $past(events.rx_buffer_full, 2)) else $error("rx flag wrong");
	tx_level_a: assert property (rda && paddr == OFF_FLAGS_ONE
		|-> prdata[SERIAL_TX_BIT] == $past(events.tx_buffer_empty, 2)) else $error("tx flag wrong");
	upper_zero_a: assert property (rda && paddr <= OFF_ENABLES_TWO |-> prdata[31:8] == '0)
		else $error("upper bits set");
endmodule // pifb_bank_sva
bind pifb_bank pifb_bank_sva sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
	.events(events));

/* bench/testbench.sv */
// self-checking testbench of the interrupt flag bank
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench
	import pifb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx = 0, tx = 1;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [3:0] pstrb = 4'hf;
	logic [17:0] fire = '0;
	logic pready, pslverr;
	pifb_ccp_mode_e m1 = PIFB_CCP_CAPTURE, m2 = PIFB_CCP_COMPARE;
	pifb_events_s events;
	pifb_req_s irq_req;
	int num_errors = 0, num_checks = 0, cycles = 0;
	pifb_src src (.fire(fire), .rx_full(rx), .tx_empty(tx), .events(events));
	pifb_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .events(events), .capcomp_one_mode(m1),
		.capcomp_two_mode(m2), .irq_req(irq_req));
	always #20 pclk = ~pclk;
	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			num_errors++;
			give_verdict();
		end
	end
	// one transfer; the pulse vector rides in the access phase
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [17:0] f, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		fire <= f;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		fire <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [17:0] f = '0);
		logic [31:0] q;
		logic e;
		apb(a, 1, d, f, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(a, 0, '0, '0, q, e);
		`CHK(q, x)
		`CHK(e, a > OFF_REQ_STATUS)
	endtask
	task automatic pulse(input logic [17:0] f);
		@(posedge pclk);
		fire <= f;
		@(posedge pclk);
		fire <= '0;
	endtask
	task automatic irq_is(input logic [1:0] x);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		`CHK(irq_req, x)
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		rd(OFF_EXT_CTRL, 32'h0000_00c0);
		rd(OFF_FLAGS_ONE, 32'h0000_0010);
		rd(OFF_PERIPH_PRIO, 32'h0000_cfff);
		wr(OFF_EXT_CTRL, 32'h0000_00ff);
		rd(OFF_EXT_CTRL, 32'h0000_00db);
		wr(OFF_ENABLES_TWO, 32'h0000_00ff);
		rd(OFF_ENABLES_TWO, 32'h0000_00cf);
		wr(OFF_ENABLES_TWO, 32'h0000_0000);
		wr(OFF_EXT_CTRL, 32'h0000_00c0);
		pulse(18'h3_cfff);
		rd(OFF_EXT_CTRL, 32'h0000_00c3);
		rd(OFF_FLAGS_ONE, 32'h0000_00df);
		rd(OFF_FLAGS_TWO, 32'h0000_00cf);
		wr(OFF_FLAGS_TWO, 32'h0000_0000);
		rd(OFF_FLAGS_TWO, 32'h0000_0000);
		wr(OFF_FLAGS_ONE, 32'h0000_0000);
		m1 <= PIFB_CCP_PWM;
		m2 <= PIFB_CCP_OFF;
		pulse(18'h0_0603);
		rd(OFF_FLAGS_ONE, 32'h0000_0010);
		m1 <= PIFB_CCP_COMPARE;
		m2 <= PIFB_CCP_CAPTURE;
		pulse(18'h0_0401);
		rd(OFF_FLAGS_TWO, 32'h0000_0000);
		pulse(18'h0_0202);
		rd(OFF_FLAGS_ONE, 32'h0000_0014);
		rd(OFF_FLAGS_TWO, 32'h0000_0001);
		wr(OFF_FLAGS_ONE, 32'h0000_0000, 18'h0_0080);
		rd(OFF_FLAGS_ONE, 32'h0000_0011);
		rx <= 1;
		tx <= 0;
		wr(OFF_FLAGS_ONE, 32'h0000_00ff);
		rd(OFF_FLAGS_ONE, 32'h0000_00ef);
		rx <= 0;
		tx <= 1;
		wr(OFF_FLAGS_ONE, 32'h0000_0000);
		rd(OFF_FLAGS_ONE, 32'h0000_0010);
		wr(OFF_PERIPH_PRIO, 32'h0000_0000);
		wr(OFF_ENABLES_ONE, 32'h0000_0001);
		pulse(18'h0_0080);
		wr(OFF_GLOBAL_CTRL, 32'h0000_0001);
		irq_is(2'b00);
		wr(OFF_GLOBAL_CTRL, 32'h0000_0003);
		irq_is(2'b10);
		rd(OFF_REQ_STATUS, 32'h0000_0002);
		wr(OFF_GLOBAL_CTRL, 32'h0000_0007);
		irq_is(2'b01);
		wr(OFF_PERIPH_PRIO, 32'h0000_0001);
		irq_is(2'b10);
		wr(OFF_ENABLES_ONE, 32'h0000_0000);
		irq_is(2'b00);
		wr(OFF_EXT_CTRL, 32'h0000_0048, 18'h1_0000);
		irq_is(2'b10);
		wr(OFF_EXT_CTRL, 32'h0000_0008, 18'h1_0000);
		irq_is(2'b01);
		rd(8'h40, 32'h0000_0000);
		give_verdict();
	end
endmodule // testbench
